//--- hw/flash_host_pkg.sv
// Package for the flash bus host controller: command codes, pin widths,
// software register map and timing counts.
// Assumes a 250 MHz system clock and a boot-block parallel flash on the pins.
package flash_host_pkg;
	// Pin widths
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	// Flash command codes
	localparam logic [7:0] CMD_INVALID = 8'h00;
	localparam logic [7:0] CMD_ALT_PROG = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	// Identifier locations
	localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 18'h00000;
	localparam logic [ADDR_W-1:0] ID_PART_ADDR = 18'h00001;
	// Flash status bits
	localparam int SR_READY_BIT = 7;
	localparam int SR_ERASE_ERR_BIT = 5;
	localparam int SR_PROG_ERR_BIT = 4;
	// Software register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_WDATA = 4'h2;
	localparam logic [3:0] REG_GO = 4'h3;
	localparam logic [3:0] REG_RDATA = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	// Control fields
	localparam int CTRL_RESET_BIT = 0;
	localparam int CTRL_BYTE_BIT = 1;
	localparam int CTRL_VPP_BIT = 2;
	localparam int CTRL_UNLOCK_BIT = 3;
	localparam int CTRL_IDPIN_BIT = 4;
	localparam logic [4:0] CTRL_RESET_VAL = 5'h01;
	// GO fields: bit 0 write, bit 1 read
	localparam int GO_WRITE_BIT = 0;
	localparam int GO_READ_BIT = 1;
	// Timing in ns and derived cycles
	localparam int CLK_NS = 4;
	localparam int ACCESS_NS = 90;
	localparam int WE_PULSE_NS = 50;
	localparam int RP_LOW_NS = 100;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC = (RP_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 6;

	// Pin bundle towards the flash
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic byte_n;
		logic vpp_high;
		logic boot_unlock_voltage;
		logic id_select_voltage;
		logic [ADDR_W-1:0] addr;
	} flash_ctl_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WR = 3'b001,
		ST_WR_HOLD = 3'b010,
		ST_RD = 3'b011,
		ST_RD_DONE = 3'b100,
		ST_PD = 3'b101
	} bus_state_e;
endpackage

//--- hw/flash_bus_host.sv
// Function
// - Reads assert reset high, chip select low, output enable low together.
// - Commands are writes with chip select, write enable low, output high.
// - Host must write array-read to leave identifier mode.
// - Flash reset/power-down follows the host logic reset; here it is also entered when software clears the CTRL reset bit.
//
// Host side controller for a boot-block parallel flash. Software orders
// single write or read cycles through a small register port.
// Assumes the flash data pins are resolved outside from the enables.
`timescale 1ns/1ps
module flash_bus_host
	import flash_host_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	output flash_ctl_s flash_ctl,
	output logic reset_powerdown_n,
	input wire logic [DATA_W-1:0] data_pins_in,
	output logic [DATA_W-1:0] data_pins_out,
	output logic [DATA_W-1:0] data_pins_oe_n
);

	bus_state_e state_q;
	logic [4:0] ctrl_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] rdata_q;
	logic [CNT_W-1:0] cnt_q;
	logic [7:0] last_cmd_q;
	logic busy_flag_q;
	logic pd_done_q;

	// Register decode used by the write path and the GO decode
	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		return a == r;
	endfunction

	wire logic busy = (state_q != ST_IDLE);
	wire logic go_wr = reg_write && hit(reg_addr, REG_GO) && reg_wdata[GO_WRITE_BIT] && !busy;
	wire logic go_rd = reg_write && hit(reg_addr, REG_GO) && reg_wdata[GO_READ_BIT]
		&& !reg_wdata[GO_WRITE_BIT] && !busy;

	// Software control register; power-down request enters its own state
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrl_q <= CTRL_RESET_VAL;
			addr_q <= '0;
			wdata_q <= '0;
		end else if (reg_write) begin
			if (hit(reg_addr, REG_CTRL))
				ctrl_q <= reg_wdata[4:0];
			if (hit(reg_addr, REG_ADDR))
				addr_q <= reg_wdata[ADDR_W-1:0];
			if (hit(reg_addr, REG_WDATA))
				wdata_q <= reg_wdata[DATA_W-1:0];
		end
	end

	// Bus cycle sequencer
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= ST_PD;
			cnt_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					cnt_q <= '0;
					if (!ctrl_q[CTRL_RESET_BIT])
						state_q <= ST_PD;
					else if (go_wr)
						state_q <= ST_WR;
					else if (go_rd)
						state_q <= ST_RD;
				end
				ST_WR: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == CNT_W'(WE_CYC - 1)) begin
						state_q <= ST_WR_HOLD;
						cnt_q <= '0;
					end
				end
				ST_WR_HOLD: state_q <= ST_IDLE;
				ST_RD: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == CNT_W'(ACCESS_CYC - 1))
						state_q <= ST_RD_DONE;
				end
				ST_RD_DONE: state_q <= ST_IDLE;
				ST_PD: begin
					if (cnt_q != CNT_W'(RP_CYC))
						cnt_q <= cnt_q + 1'b1;
					else if (ctrl_q[CTRL_RESET_BIT]) begin
						state_q <= ST_IDLE;
						cnt_q <= '0;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Capture read data at the end of the access time
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			rdata_q <= '0;
		else if (state_q == ST_RD && cnt_q == CNT_W'(ACCESS_CYC - 1))
			rdata_q <= ctrl_q[CTRL_BYTE_BIT] ? {8'h00, data_pins_in[7:0]} : data_pins_in;
	end

	// Track last command and whether a program or erase may be running
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			last_cmd_q <= CMD_READ_ARRAY;
			busy_flag_q <= 1'b0;
		end else if (state_q == ST_PD) begin
			last_cmd_q <= CMD_READ_ARRAY;
			busy_flag_q <= 1'b0;
		end else if (state_q == ST_WR_HOLD) begin
			last_cmd_q <= wdata_q[7:0];
			if ((last_cmd_q == CMD_PROG_SETUP || last_cmd_q == CMD_ALT_PROG
				|| (last_cmd_q == CMD_ERASE_SETUP && wdata_q[7:0] == CMD_CONFIRM))
				&& ctrl_q[CTRL_VPP_BIT])
				busy_flag_q <= 1'b1;
		end else if (state_q == ST_RD_DONE && last_cmd_q == CMD_READ_STATUS
			&& rdata_q[SR_READY_BIT])
			busy_flag_q <= 1'b0;
	end

	// Pins: levels from register flops, strobes and reset/power-down decoded from state
	always_comb begin
		flash_ctl.ce_n = !(state_q == ST_WR || state_q == ST_WR_HOLD || state_q == ST_RD);
		flash_ctl.oe_n = !(state_q == ST_RD);
		flash_ctl.we_n = !(state_q == ST_WR);
		flash_ctl.byte_n = !ctrl_q[CTRL_BYTE_BIT];
		flash_ctl.vpp_high = ctrl_q[CTRL_VPP_BIT];
		flash_ctl.boot_unlock_voltage = ctrl_q[CTRL_UNLOCK_BIT];
		flash_ctl.id_select_voltage = ctrl_q[CTRL_IDPIN_BIT];
		flash_ctl.addr = addr_q;
		reset_powerdown_n = (state_q != ST_PD);
	end

	// Data pins: driven in write cycles, plus the top pin in byte-mode reads; top pin carries byte address
	always_comb begin
		data_pins_out = wdata_q;
		data_pins_oe_n = '1;
		if (state_q == ST_WR || state_q == ST_WR_HOLD) begin
			data_pins_oe_n = ctrl_q[CTRL_BYTE_BIT] ? 16'h7f00 : 16'h0000;
		end else if (state_q == ST_RD && ctrl_q[CTRL_BYTE_BIT]) begin
			data_pins_oe_n = 16'h7fff;
		end
		if (ctrl_q[CTRL_BYTE_BIT])
			data_pins_out[15] = addr_q[0];
	end

	// Power-down completion flag for software
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			pd_done_q <= 1'b0;
		else
			pd_done_q <= (state_q != ST_PD);
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			reg_rdata <= '0;
		else if (reg_read) begin
			case (reg_addr)
				REG_CTRL: reg_rdata <= {27'h0, ctrl_q};
				REG_ADDR: reg_rdata <= {14'h0, addr_q};
				REG_WDATA: reg_rdata <= {16'h0, wdata_q};
				REG_RDATA: reg_rdata <= {16'h0, rdata_q};
				REG_STATUS: reg_rdata <= {20'h0, last_cmd_q, 1'b0, pd_done_q, busy_flag_q, busy};
				default: reg_rdata <= 32'h0;
			endcase
		end else
			reg_rdata <= 32'h0;
	end

	// Assertions
	a_read_needs_enables: assert property (@(posedge mclk) disable iff (reset)
		!flash_ctl.oe_n |-> (!flash_ctl.ce_n && reset_powerdown_n && flash_ctl.we_n))
		else $error("read without chip select or reset high");
	a_oe_high_float: assert property (@(posedge mclk) disable iff (reset)
		!flash_ctl.oe_n |-> (data_pins_oe_n[7:0] == 8'hff))
		else $error("host drives data during read");
	a_write_shape: assert property (@(posedge mclk) disable iff (reset)
		!flash_ctl.we_n |-> (flash_ctl.oe_n && !flash_ctl.ce_n && data_pins_oe_n[7:0] == 8'h00))
		else $error("bad write cycle");
	a_we_pulse_len: assert property (@(posedge mclk) disable iff (reset)
		$fell(flash_ctl.we_n) |-> !flash_ctl.we_n [*8] ##1 !flash_ctl.we_n [*5] ##1 flash_ctl.we_n)
		else $error("write pulse length wrong");
	a_standby_idle: assert property (@(posedge mclk) disable iff (reset)
		flash_ctl.ce_n |-> (flash_ctl.oe_n && flash_ctl.we_n))
		else $error("strobes active while deselected");
	a_pd_floats: assert property (@(posedge mclk) disable iff (reset)
		!reset_powerdown_n |-> (flash_ctl.ce_n && data_pins_oe_n == 16'hffff))
		else $error("pins active in power-down");
	a_byte_mid_float: assert property (@(posedge mclk) disable iff (reset)
		ctrl_q[CTRL_BYTE_BIT] |-> (data_pins_oe_n[14:8] == 7'h7f))
		else $error("middle byte driven in byte mode");
	a_read_captures: assert property (@(posedge mclk) disable iff (reset)
		$fell(flash_ctl.oe_n) |-> ##(ACCESS_CYC) (state_q == ST_RD_DONE))
		else $error("read not finished on time");
	a_cmd_latched: assert property (@(posedge mclk) disable iff (reset)
		(state_q == ST_WR_HOLD) |=> (last_cmd_q == $past(wdata_q[7:0])))
		else $error("command not recorded");
	c_write_cycle: cover property (@(posedge mclk) disable iff (reset) state_q == ST_WR_HOLD);
	c_read_cycle: cover property (@(posedge mclk) disable iff (reset) state_q == ST_RD_DONE);
	c_power_down: cover property (@(posedge mclk) disable iff (reset) $rose(reset_powerdown_n));

endmodule

//--- bench/flash_device_model.sv
// Behavioural boot-block flash: command decode, read paths, status and lock.
// Assumes the bench resolves the shared data pins from the host's enables.
`timescale 1ns/1ps
module flash_device_model
	import flash_host_pkg::*;
#(
	parameter logic [15:0] MAKER = 16'h5a01, // Arbitrary value
	parameter logic [15:0] PART = 16'h5a02, // Arbitrary value
	parameter logic [17:0] BOOT_END = 18'h02000,
	parameter int BUSY_NS = 600,
	parameter int RD_NS = 80
)(
	input flash_ctl_s ctl,
	input wire logic rp_n,
	input wire logic [15:0] dq,
	output wire [15:0] q
);
	logic [15:0] mem [logic [17:0]];
	logic [7:0] sr = 8'h80;
	logic [15:0] hold = '0;
	int mode = 0;
	int pend = 0;
	logic busy = 1'b0;
	wire drive = rp_n & ~ctl.ce_n & ~ctl.oe_n;
	// Read path value for the present mode
	function automatic logic [15:0] rd_val(int m, logic [7:0] s, logic [17:0] a, logic idv, logic bn, logic b15);
		logic [15:0] w;
		w = mem.exists(a) ? mem[a] : 16'hffff;
		if (idv || m == 1) return bn ? (a[0] ? PART : MAKER) : {8'h00, a[0] ? PART[7:0] : MAKER[7:0]};
		if (m == 2) return {8'h00, s};
		return bn ? w : {8'h00, b15 ? w[15:8] : w[7:0]};
	endfunction
	// Slow answer; released pins show the inverse of the last value
	assign #(RD_NS) q = drive ? rd_val(mode, sr, ctl.addr, ctl.id_select_voltage, ctl.byte_n, dq[15]) : ~hold;
	always @(negedge drive) hold = q;
	// Power-down resets the state machine and read path
	always @(negedge rp_n) begin
		mode = 0;
		pend = 0;
		busy = 1'b0;
		sr = 8'h80;
	end
	// Commands latch on the rising write strobe
	always @(posedge ctl.we_n) begin
		if (rp_n === 1'b1 && ctl.ce_n === 1'b0 && ctl.oe_n === 1'b1) take(ctl.addr, dq);
	end
	task automatic take(logic [17:0] a, logic [15:0] d);
		if (busy) begin
			if (d[7:0] == 8'h70) mode = 2;
		end else if (pend != 0) begin
			mode = 2;
			if (a < BOOT_END && !ctl.boot_unlock_voltage) sr[pend == 1 ? 4 : 5] = 1'b1;
			else if (ctl.vpp_high) begin
				if (pend == 1) mem[a] = d;
				busy = 1'b1;
				sr[7] = 1'b0;
				fork begin #(BUSY_NS); busy = 1'b0; sr[7] = 1'b1; end join_none
			end
			pend = 0;
		end else begin
			case (d[7:0])
				8'hff: mode = 0;
				8'h90: mode = 1;
				8'h70: mode = 2;
				8'h50: sr[5:3] = 3'h0;
				8'h40, 8'h10, 8'h20: pend = (d[7:0] == 8'h20) ? 2 : 1;
				default: ;
			endcase
		end
	endtask
endmodule

//--- bench/flash_bus_command_front_end_bench.sv
// Self-checking bench for the flash bus host controller.
// Assumes the behavioural flash model on the far side of the pins.
`timescale 1ns/1ps
module flash_bus_command_front_end_bench;
	import flash_host_pkg::*;
	localparam logic [15:0] MAKER = 16'h5a01; // Arbitrary value
	localparam logic [15:0] PART = 16'h5a02; // Arbitrary value
	typedef struct packed {logic [7:0] cmd; logic [17:0] ra; logic [15:0] exp;} row_s;
	row_s rows [6] = '{'{8'h90, 18'h0, MAKER}, '{8'h90, 18'h1, PART}, '{8'h70, 18'h5, 16'h0080},
		'{8'hff, 18'h100, 16'hffff}, '{8'h00, 18'h100, 16'hffff}, '{8'h50, 18'h100, 16'hffff}};
	logic mclk, reset, reg_write, reg_read, rp_n;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	flash_ctl_s ctl;
	logic [15:0] dq_out, dq_oe_n;
	wire [15:0] q;
	wire [15:0] bus = (dq_out & ~dq_oe_n) | (q & dq_oe_n);
	int error_cnt, n_compared, i;
	flash_bus_host u_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .flash_ctl(ctl),
		.reset_powerdown_n(rp_n), .data_pins_in(bus), .data_pins_out(dq_out), .data_pins_oe_n(dq_oe_n));
	flash_device_model #(.MAKER(MAKER), .PART(PART)) u_flash (.ctl(ctl), .rp_n(rp_n), .dq(bus), .q(q));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic check(logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic reg_wr(logic [3:0] a, logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	task automatic reg_rd(logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// One flash cycle through the register port, polled under a bound
	task automatic fop(logic [31:0] go, logic [17:0] a, logic [15:0] d);
		logic [31:0] s;
		reg_wr(REG_ADDR, {14'h0, a});
		reg_wr(REG_WDATA, {16'h0, d});
		reg_wr(REG_GO, go);
		for (int k = 0; k < 100; k++) begin
			reg_rd(REG_STATUS, s);
			if (s[0] === 1'b0) return;
		end
		error_cnt++;
		give_verdict();
	endtask
	task automatic frd(logic [17:0] a, output logic [31:0] d);
		fop(32'h2, a, 16'h0);
		reg_rd(REG_RDATA, d);
	endtask
	initial begin
		reset = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		error_cnt = 0;
		n_compared = 0;
		repeat (12) @(posedge mclk);
		check({15'h0, rp_n}, 16'h0000);
		reset <= 1'b0;
		for (i = 0; i < 60 && rp_n !== 1'b1; i++) @(posedge mclk);
		check({15'h0, rp_n}, 16'h0001);
		reg_rd(4'hf, rd);
		check(rd[15:0], 16'h0000);
		$display("reset test done");
		// Ordinary commands followed by one read each
		for (i = 0; i < 6; i++) begin
			fop(32'h1, 18'h0, {8'h00, rows[i].cmd});
			frd(rows[i].ra, rd);
			check(rd[15:0], rows[i].exp);
		end
		$display("command table done");
		// Program while supply high; other commands refused while busy
		reg_wr(REG_CTRL, 32'h5);
		fop(32'h1, 18'h2000, 16'h0040);
		fop(32'h1, 18'h2000, 16'h1234);
		reg_rd(REG_STATUS, rd);
		check({15'h0, rd[1]}, 16'h0001);
		fop(32'h1, 18'h0, 16'h0090);
		frd(18'h0, rd);
		check(rd[15:0], 16'h0000);
		for (i = 0; i < 40 && rd[7] !== 1'b1; i++) frd(18'h0, rd);
		check(rd[15:0], 16'h0080);
		fop(32'h1, 18'h0, 16'h00ff);
		frd(18'h2000, rd);
		check(rd[15:0], 16'h1234);
		// Program refused with supply low
		reg_wr(REG_CTRL, 32'h1);
		fop(32'h1, 18'h2001, 16'h0040);
		fop(32'h1, 18'h2001, 16'h5678);
		fop(32'h1, 18'h0, 16'h00ff);
		frd(18'h2001, rd);
		check(rd[15:0], 16'hffff);
		// Locked boot block: program then erase flag failures
		reg_wr(REG_CTRL, 32'h5);
		fop(32'h1, 18'h10, 16'h0040);
		fop(32'h1, 18'h10, 16'habcd);
		frd(18'h0, rd);
		check(rd[15:0], 16'h0090);
		fop(32'h1, 18'h10, 16'h0020);
		fop(32'h1, 18'h10, 16'h00d0);
		frd(18'h0, rd);
		check(rd[15:0], 16'h00b0);
		fop(32'h1, 18'h0, 16'h0050);
		fop(32'h1, 18'h0, 16'h0070);
		frd(18'h0, rd);
		check(rd[15:0], 16'h0080);
		$display("program and lock tests done");
		// Identifier by pin voltage, word then byte mode
		fop(32'h1, 18'h0, 16'h00ff);
		reg_wr(REG_CTRL, 32'h11);
		frd(18'h1, rd);
		check(rd[15:0], PART);
		reg_wr(REG_CTRL, 32'h13);
		frd(18'h0, rd);
		check({8'h00, rd[7:0]}, {8'h00, MAKER[7:0]});
		// Power-down in identifier mode returns to array reads
		reg_wr(REG_CTRL, 32'h1);
		fop(32'h1, 18'h0, 16'h0090);
		reg_wr(REG_CTRL, 32'h0);
		repeat (4) @(posedge mclk);
		check({15'h0, rp_n}, 16'h0000);
		reg_wr(REG_CTRL, 32'h1);
		for (i = 0; i < 60 && rp_n !== 1'b1; i++) @(posedge mclk);
		check({15'h0, rp_n}, 16'h0001);
		frd(18'h1, rd);
		check(rd[15:0], 16'hffff);
		$display("identifier and power-down tests done");
		give_verdict();
	end
endmodule
